//--- shared/dmst_pkg.sv
package dmst_pkg;

    // Clock
    localparam int CLK_PERIOD_NS = 25;

    // Rounds a least time up to whole cycles, never below one
    function automatic int cyc_min(input int ns);
        int c;
        c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
        return (c < 1) ? 1 : c;
    endfunction : cyc_min

    // Rounds a longest time down to whole cycles, never below one
    function automatic int cyc_max(input int ns);
        int c;
        c = ns / CLK_PERIOD_NS;
        return (c < 1) ? 1 : c;
    endfunction : cyc_max

    // Strobe timing in ns, refresh interval in ms and row count, slowest grade so every grade is met
    localparam int PAGE_CYCLE_MIN_NS           = 55;
    localparam int COLUMN_PRECHARGE_MIN_NS     = 10;
    localparam int COLUMN_LOW_WIDTH_MIN_NS     = 25;
    localparam int COLUMN_LOW_WIDTH_MAX_NS     = 10000;
    localparam int ROW_PRECHARGE_MIN_NS        = 70;
    localparam int ROW_LOW_WIDTH_MIN_NS        = 100;
    localparam int ROW_LOW_WIDTH_MAX_NS        = 10000;
    localparam int ROW_TO_COLUMN_DELAY_NS      = 25;
    localparam int ROW_TO_COLADDR_DELAY_NS     = 20;
    localparam int COLUMN_RELEASE_AFTER_ROW_NS = 100;
    localparam int REFRESH_COLUMN_HOLD_NS      = 25;
    localparam int REFRESH_COLUMN_LEAD_NS      = 10;
    localparam int REFRESH_INTERVAL_MS         = 8;
    localparam int REFRESH_ROWS                = 512;

    // Derived cycle counts
    localparam int PAGE_CYCLE_MIN_CYC           = cyc_min(PAGE_CYCLE_MIN_NS);
    localparam int COLUMN_PRECHARGE_MIN_CYC     = cyc_min(COLUMN_PRECHARGE_MIN_NS);
    localparam int COLUMN_LOW_WIDTH_MIN_CYC     = cyc_min(COLUMN_LOW_WIDTH_MIN_NS);
    localparam int COLUMN_LOW_WIDTH_MAX_CYC     = cyc_max(COLUMN_LOW_WIDTH_MAX_NS);
    localparam int ROW_PRECHARGE_MIN_CYC        = cyc_min(ROW_PRECHARGE_MIN_NS);
    localparam int ROW_LOW_WIDTH_MIN_CYC        = cyc_min(ROW_LOW_WIDTH_MIN_NS);
    localparam int ROW_LOW_WIDTH_MAX_CYC        = cyc_max(ROW_LOW_WIDTH_MAX_NS);
    localparam int ROW_TO_COLUMN_DELAY_CYC      = cyc_min(ROW_TO_COLUMN_DELAY_NS);
    localparam int ROW_TO_COLADDR_DELAY_CYC     = cyc_min(ROW_TO_COLADDR_DELAY_NS);
    localparam int COLUMN_RELEASE_AFTER_ROW_CYC = cyc_min(COLUMN_RELEASE_AFTER_ROW_NS);
    localparam int REFRESH_COLUMN_HOLD_CYC      = cyc_min(REFRESH_COLUMN_HOLD_NS);
    localparam int REFRESH_COLUMN_LEAD_CYC      = cyc_min(REFRESH_COLUMN_LEAD_NS);
    localparam int REFRESH_STEP_CYC             = cyc_max((REFRESH_INTERVAL_MS * 1000000) / REFRESH_ROWS);

    // Controller sizing
    localparam int SYNC_STAGES     = 3;
    localparam int READ_SAMPLE_CYC = SYNC_STAGES + 2;
    localparam int ROW_CLOSE_GUARD = 8;
    localparam int ROW_CLOSE_CYC   = ROW_LOW_WIDTH_MAX_CYC - ROW_CLOSE_GUARD;
    localparam int TMR_W           = 12;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_ROW_ACT,
        ST_COL_ADDR,
        ST_COL_LOW,
        ST_COL_HIGH,
        ST_REF_LEAD,
        ST_REF_RAS
    } dmst_state_t;

endpackage : dmst_pkg

//--- core/dmst_sync.sv
`timescale 1ns/100ps
module dmst_sync #(
    parameter int WIDTH = 36
) (
    // Clock and reset
    input  wire logic             clk,
    input  wire logic             nrst,
    // Pin side and synchronised side
    input  wire logic [WIDTH-1:0] din,
    output logic      [WIDTH-1:0] dout
);

    logic [WIDTH-1:0] s1_reg;
    logic [WIDTH-1:0] s2_reg;
    logic [WIDTH-1:0] s3_reg;
    logic [WIDTH-1:0] dout_reg;
    logic [WIDTH-1:0] dout_next;

    // Per bit: a change counts only once the last two stages agree
    for (genvar i = 0; i < WIDTH; i++) begin : g_bit
        always_comb begin
            dout_next[i] = (s2_reg[i] == s3_reg[i]) ? s3_reg[i] : dout_reg[i];
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            s1_reg   <= '0;
            s2_reg   <= '0;
            s3_reg   <= '0;
            dout_reg <= '0;
        end else begin
            s1_reg   <= din;
            s2_reg   <= s1_reg;
            s3_reg   <= s2_reg;
            dout_reg <= dout_next;
        end
    end

    assign dout = dout_reg;

endmodule : dmst_sync

//--- core/dmst_refresh_timer.sv
`timescale 1ns/100ps
module dmst_refresh_timer #(
    parameter int STEP_CYC = dmst_pkg::REFRESH_STEP_CYC
) (
    // Clock and reset
    input  wire logic clk,
    input  wire logic nrst,
    // Refresh handshake
    input  wire logic ack,
    output logic      pending
);

    logic [15:0] cnt_reg;
    logic [15:0] cnt_next;
    logic [1:0]  owed_reg;
    logic [1:0]  owed_next;
    logic        tick;

    always_comb begin
        tick     = (cnt_reg == 16'(STEP_CYC - 1));
        cnt_next = tick ? 16'h0000 : cnt_reg + 16'h0001;
        owed_next = owed_reg;
        // A tick in the same cycle as an ack leaves the debt unchanged
        if (tick && !ack && owed_reg != 2'h3) begin
            owed_next = owed_reg + 2'h1;
        end else if (!tick && ack && owed_reg != 2'h0) begin
            owed_next = owed_reg - 2'h1;
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            cnt_reg  <= '0;
            owed_reg <= '0;
        end else begin
            cnt_reg  <= cnt_next;
            owed_reg <= owed_next;
        end
    end

    assign pending = (owed_reg != 2'h0);

    a_refresh_served: assert property (@(posedge clk) disable iff (!nrst)
        $rose(pending) |-> ##[0:500] ack)
        else $error("refresh request not served in time");

    a_refresh_owed: assert property (@(posedge clk) disable iff (!nrst)
        owed_reg <= 2'h1)
        else $error("refresh debt piled up");

endmodule : dmst_refresh_timer

//--- core/dmst_ctrl.sv
`timescale 1ns/100ps
module dmst_ctrl #(
    parameter int ADDR_W   = 9,
    parameter int DATA_W   = 36,
    parameter int STEP_CYC = dmst_pkg::REFRESH_STEP_CYC
) (
    // Clock and reset
    input  wire logic              clk,
    input  wire logic              nrst,
    // User request
    input  wire logic              req_valid,
    input  wire logic              req_write,
    input  wire logic [ADDR_W-1:0] req_row,
    input  wire logic [ADDR_W-1:0] req_col,
    input  wire logic [DATA_W-1:0] req_wdata,
    output logic                   req_ready,
    // User read answer
    output logic                   rd_valid,
    output logic      [DATA_W-1:0] rd_data,
    // Memory pins
    output logic                   ras_n,
    output logic                   cas_n,
    output logic                   we_n,
    output logic      [ADDR_W-1:0] mem_addr,
    input  wire logic [DATA_W-1:0] dq_in,
    output logic      [DATA_W-1:0] dq_out,
    output logic                   dq_oe
);

    localparam logic [dmst_pkg::TMR_W-1:0] TMR_SAT = '1;
    localparam logic [dmst_pkg::TMR_W-1:0] TMR_ONE = {{(dmst_pkg::TMR_W-1){1'b0}}, 1'b1};

    dmst_pkg::dmst_state_t state_reg;
    dmst_pkg::dmst_state_t state_next;

    logic                      ras_n_reg;
    logic                      ras_n_next;
    logic                      cas_n_reg;
    logic                      cas_n_next;
    logic                      we_n_reg;
    logic                      we_n_next;
    logic [ADDR_W-1:0]         addr_reg;
    logic [ADDR_W-1:0]         addr_next;
    logic [DATA_W-1:0]         dq_out_reg;
    logic [DATA_W-1:0]         dq_out_next;
    logic                      dq_oe_reg;
    logic                      dq_oe_next;
    logic                      req_ready_reg;
    logic                      req_ready_next;
    logic                      rd_valid_reg;
    logic                      rd_valid_next;
    logic [DATA_W-1:0]         rd_data_reg;
    logic [DATA_W-1:0]         rd_data_next;
    logic [ADDR_W-1:0]         open_row_reg;
    logic [ADDR_W-1:0]         open_row_next;
    logic                      is_write_reg;
    logic                      is_write_next;
    logic                      col_sel_reg;
    logic                      col_sel_next;
    logic [dmst_pkg::TMR_W-1:0] ras_tmr_reg;
    logic [dmst_pkg::TMR_W-1:0] ras_tmr_next;
    logic [dmst_pkg::TMR_W-1:0] cas_tmr_reg;
    logic [dmst_pkg::TMR_W-1:0] cas_tmr_next;
    logic [dmst_pkg::TMR_W-1:0] page_tmr_reg;
    logic [dmst_pkg::TMR_W-1:0] page_tmr_next;
    logic                      take_req;
    logic                      ref_ack;
    logic                      ref_pending;
    logic [DATA_W-1:0]         rd_sync;

    dmst_sync #(
        .WIDTH (DATA_W)
    ) u_sync (
        .clk  (clk),
        .nrst (nrst),
        .din  (dq_in),
        .dout (rd_sync)
    );

    dmst_refresh_timer #(
        .STEP_CYC (STEP_CYC)
    ) u_refresh (
        .clk     (clk),
        .nrst    (nrst),
        .ack     (ref_ack),
        .pending (ref_pending)
    );

    // Timers hold the periods that will have elapsed since the last edge at the coming clock edge
    always_comb begin
        state_next     = state_reg;
        ras_n_next     = ras_n_reg;
        cas_n_next     = cas_n_reg;
        we_n_next      = we_n_reg;
        addr_next      = addr_reg;
        dq_out_next    = dq_out_reg;
        dq_oe_next     = dq_oe_reg;
        req_ready_next = 1'b0;
        rd_valid_next  = 1'b0;
        rd_data_next   = rd_data_reg;
        open_row_next  = open_row_reg;
        is_write_next  = is_write_reg;
        col_sel_next   = col_sel_reg;
        take_req       = 1'b0;
        ref_ack        = 1'b0;
        unique case (state_reg)
            dmst_pkg::ST_IDLE: begin
                if (ras_tmr_reg >= dmst_pkg::ROW_PRECHARGE_MIN_CYC) begin
                    if (ref_pending && cas_tmr_reg >= dmst_pkg::COLUMN_PRECHARGE_MIN_CYC) begin
                        cas_n_next = 1'b0;
                        ref_ack    = 1'b1;
                        state_next = dmst_pkg::ST_REF_LEAD;
                    end else if (req_valid && !ref_pending) begin
                        ras_n_next    = 1'b0;
                        addr_next     = req_row;
                        open_row_next = req_row;
                        col_sel_next  = 1'b0;
                        state_next    = dmst_pkg::ST_ROW_ACT;
                    end
                end
            end
            dmst_pkg::ST_ROW_ACT: begin
                take_req = (ras_tmr_reg >= dmst_pkg::ROW_TO_COLADDR_DELAY_CYC);
            end
            dmst_pkg::ST_COL_ADDR: begin
                if (ras_tmr_reg >= dmst_pkg::ROW_TO_COLUMN_DELAY_CYC &&
                    cas_tmr_reg >= dmst_pkg::COLUMN_PRECHARGE_MIN_CYC &&
                    page_tmr_reg >= dmst_pkg::PAGE_CYCLE_MIN_CYC) begin
                    cas_n_next = 1'b0;
                    state_next = dmst_pkg::ST_COL_LOW;
                end
            end
            dmst_pkg::ST_COL_LOW: begin
                // Read data crosses three stages, so the low time covers the access plus that latency
                if (cas_tmr_reg >= dmst_pkg::COLUMN_LOW_WIDTH_MIN_CYC + dmst_pkg::READ_SAMPLE_CYC &&
                    ras_tmr_reg >= dmst_pkg::COLUMN_RELEASE_AFTER_ROW_CYC + dmst_pkg::READ_SAMPLE_CYC) begin
                    cas_n_next    = 1'b1;
                    we_n_next     = 1'b1;
                    dq_oe_next    = 1'b0;
                    rd_valid_next = !is_write_reg;
                    rd_data_next  = is_write_reg ? rd_data_reg : rd_sync;
                    state_next    = dmst_pkg::ST_COL_HIGH;
                end
            end
            dmst_pkg::ST_COL_HIGH: begin
                // Row stays open for page hits until refresh, a miss or the row-low limit
                if (ref_pending || ras_tmr_reg >= dmst_pkg::ROW_CLOSE_CYC ||
                    (req_valid && req_row != open_row_reg)) begin
                    if (ras_tmr_reg >= dmst_pkg::ROW_LOW_WIDTH_MIN_CYC) begin
                        ras_n_next = 1'b1;
                        state_next = dmst_pkg::ST_IDLE;
                    end
                end else begin
                    take_req = req_valid && cas_tmr_reg >= dmst_pkg::COLUMN_PRECHARGE_MIN_CYC;
                end
            end
            dmst_pkg::ST_REF_LEAD: begin
                if (cas_tmr_reg >= dmst_pkg::REFRESH_COLUMN_LEAD_CYC) begin
                    ras_n_next = 1'b0;
                    state_next = dmst_pkg::ST_REF_RAS;
                end
            end
            dmst_pkg::ST_REF_RAS: begin
                if (!cas_n_reg && ras_tmr_reg >= dmst_pkg::REFRESH_COLUMN_HOLD_CYC) begin
                    cas_n_next = 1'b1;
                end
                if (cas_n_reg && ras_tmr_reg >= dmst_pkg::ROW_LOW_WIDTH_MIN_CYC) begin
                    ras_n_next = 1'b1;
                    state_next = dmst_pkg::ST_IDLE;
                end
            end
        endcase
        if (take_req) begin
            // Write strobe and data lead the column fall, so the module drives the shared lines only for writes, never during a read
            addr_next      = req_col;
            col_sel_next   = 1'b1;
            we_n_next      = !req_write;
            dq_out_next    = req_wdata;
            dq_oe_next     = req_write;
            is_write_next  = req_write;
            req_ready_next = 1'b1;
            state_next     = dmst_pkg::ST_COL_ADDR;
        end
        ras_tmr_next  = (ras_n_next != ras_n_reg) ? TMR_ONE :
                        (ras_tmr_reg == TMR_SAT) ? TMR_SAT : ras_tmr_reg + TMR_ONE;
        cas_tmr_next  = (cas_n_next != cas_n_reg) ? TMR_ONE :
                        (cas_tmr_reg == TMR_SAT) ? TMR_SAT : cas_tmr_reg + TMR_ONE;
        page_tmr_next = (!cas_n_next && cas_n_reg) ? TMR_ONE :
                        (page_tmr_reg == TMR_SAT) ? TMR_SAT : page_tmr_reg + TMR_ONE;
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            state_reg     <= dmst_pkg::ST_IDLE;
            ras_n_reg     <= 1'b1;
            cas_n_reg     <= 1'b1;
            we_n_reg      <= 1'b1;
            addr_reg      <= '0;
            dq_out_reg    <= '0;
            dq_oe_reg     <= 1'b0;
            req_ready_reg <= 1'b0;
            rd_valid_reg  <= 1'b0;
            rd_data_reg   <= '0;
            open_row_reg  <= '0;
            is_write_reg  <= 1'b0;
            col_sel_reg   <= 1'b0;
            ras_tmr_reg   <= '1;
            cas_tmr_reg   <= '1;
            page_tmr_reg  <= '1;
        end else begin
            state_reg     <= state_next;
            ras_n_reg     <= ras_n_next;
            cas_n_reg     <= cas_n_next;
            we_n_reg      <= we_n_next;
            addr_reg      <= addr_next;
            dq_out_reg    <= dq_out_next;
            dq_oe_reg     <= dq_oe_next;
            req_ready_reg <= req_ready_next;
            rd_valid_reg  <= rd_valid_next;
            rd_data_reg   <= rd_data_next;
            open_row_reg  <= open_row_next;
            is_write_reg  <= is_write_next;
            col_sel_reg   <= col_sel_next;
            ras_tmr_reg   <= ras_tmr_next;
            cas_tmr_reg   <= cas_tmr_next;
            page_tmr_reg  <= page_tmr_next;
        end
    end

    assign req_ready = req_ready_reg;
    assign rd_valid  = rd_valid_reg;
    assign rd_data   = rd_data_reg;
    assign ras_n     = ras_n_reg;
    assign cas_n     = cas_n_reg;
    assign we_n      = we_n_reg;
    assign mem_addr  = addr_reg;
    assign dq_out    = dq_out_reg;
    assign dq_oe     = dq_oe_reg;

    a_page_cycle_min: assert property (@(posedge clk) disable iff (!nrst)
        $fell(cas_n_reg) |-> $past(page_tmr_reg) >= dmst_pkg::PAGE_CYCLE_MIN_CYC)
        else $error("column falls closer than the page cycle");

    a_column_precharge: assert property (@(posedge clk) disable iff (!nrst)
        $fell(cas_n_reg) |-> $past(cas_tmr_reg) >= dmst_pkg::COLUMN_PRECHARGE_MIN_CYC)
        else $error("column high period too short");

    a_column_low_width: assert property (@(posedge clk) disable iff (!nrst)
        $rose(cas_n_reg) |-> $past(cas_tmr_reg) >= dmst_pkg::COLUMN_LOW_WIDTH_MIN_CYC &&
                             $past(cas_tmr_reg) <= dmst_pkg::COLUMN_LOW_WIDTH_MAX_CYC)
        else $error("column low width out of range");

    a_row_precharge: assert property (@(posedge clk) disable iff (!nrst)
        $fell(ras_n_reg) |-> $past(ras_tmr_reg) >= dmst_pkg::ROW_PRECHARGE_MIN_CYC)
        else $error("row precharge too short");

    a_row_low_min: assert property (@(posedge clk) disable iff (!nrst)
        $rose(ras_n_reg) |-> $past(ras_tmr_reg) >= dmst_pkg::ROW_LOW_WIDTH_MIN_CYC)
        else $error("row low width too short");

    a_row_low_max: assert property (@(posedge clk) disable iff (!nrst)
        !ras_n_reg |-> ras_tmr_reg <= dmst_pkg::ROW_LOW_WIDTH_MAX_CYC)
        else $error("row held low beyond its maximum");

    a_row_to_column: assert property (@(posedge clk) disable iff (!nrst)
        $fell(cas_n_reg) && !ras_n_reg |-> $past(ras_tmr_reg) >= dmst_pkg::ROW_TO_COLUMN_DELAY_CYC)
        else $error("column fell too soon after row");

    a_coladdr_delay: assert property (@(posedge clk) disable iff (!nrst)
        $rose(col_sel_reg) |-> !ras_n_reg && $past(ras_tmr_reg) >= dmst_pkg::ROW_TO_COLADDR_DELAY_CYC)
        else $error("column address driven too soon after row");

    a_column_release: assert property (@(posedge clk) disable iff (!nrst)
        $rose(cas_n_reg) && $past(state_reg) == dmst_pkg::ST_COL_LOW |->
            $past(ras_tmr_reg) >= dmst_pkg::COLUMN_RELEASE_AFTER_ROW_CYC)
        else $error("column released too soon after row");

    a_refresh_hold: assert property (@(posedge clk) disable iff (!nrst)
        $rose(cas_n_reg) && $past(state_reg) == dmst_pkg::ST_REF_RAS |->
            $past(ras_tmr_reg) >= dmst_pkg::REFRESH_COLUMN_HOLD_CYC)
        else $error("refresh column hold too short");

    a_refresh_lead: assert property (@(posedge clk) disable iff (!nrst)
        $fell(ras_n_reg) && !cas_n_reg |-> $past(cas_tmr_reg) >= dmst_pkg::REFRESH_COLUMN_LEAD_CYC && we_n_reg)
        else $error("refresh column lead too short");

    a_read_hold: assert property (@(posedge clk) disable iff (!nrst)
        $rose(cas_n_reg) && !$past(is_write_reg) |-> we_n_reg && $past(we_n_reg))
        else $error("write strobe low at end of read");

    a_early_write: assert property (@(posedge clk) disable iff (!nrst)
        $fell(cas_n_reg) && !we_n_reg |-> $past(!we_n_reg) && $past(dq_oe_reg) && dq_oe_reg)
        else $error("write not set up before column fall");

    a_read_no_drive: assert property (@(posedge clk) disable iff (!nrst)
        !cas_n_reg && we_n_reg |-> !dq_oe_reg)
        else $error("data lines driven during read");

endmodule : dmst_ctrl

//--- testbench/dmst_mem_model.sv
`timescale 1ns/100ps
module dmst_mem_model (
    // Strobes and address
    input  wire logic        ras_n,
    input  wire logic        cas_n,
    input  wire logic        we_n,
    input  wire logic [8:0]  mem_addr,
    // Shared data lines
    input  wire logic [35:0] dq_out,
    output logic      [35:0] dq_in,
    output int               refreshes
);
    logic [35:0] cells [bit [17:0]];
    logic [8:0]  row_reg;

    initial begin
        dq_in = 36'h0;
        refreshes = 0;
        row_reg = 9'h0;
    end

    // Column low at the row fall means an internal refresh; the address is ignored
    always @(negedge ras_n) begin
        if (!cas_n) refreshes = refreshes + 1;
        else row_reg = mem_addr;
    end

    always @(negedge cas_n) begin
        if (!ras_n && !we_n) cells[{row_reg, mem_addr}] = dq_out;
        else if (!ras_n) dq_in <= #15 cells.exists({row_reg, mem_addr}) ? cells[{row_reg, mem_addr}] : 36'h0;
    end

    // Released lines float, so show the inverse rather than a stale word
    always @(posedge cas_n) dq_in = ~dq_in;
endmodule : dmst_mem_model

//--- testbench/dram_module_strobe_timing_tb.sv
`timescale 1ns/100ps
module dram_module_strobe_timing_tb;
    localparam int STEP = 40;
    logic clk = 1'b0, nrst, req_valid, req_write, req_ready, rd_valid, ras_n, cas_n, we_n, dq_oe, ras_prev;
    logic [8:0]  req_row, req_col, mem_addr;
    logic [35:0] req_wdata, rd_data, dq_in, dq_out;
    logic [35:0] ref_mem [bit [17:0]];
    int errors = 0, compares = 0, cyc = 0, cas_low = 0, ras_low = 0, refreshes, seed, i;
    logic [8:0]  r, c;

    always #12.5 clk = ~clk;

    dmst_ctrl #(.STEP_CYC(STEP)) uut (
        .clk(clk), .nrst(nrst), .req_valid(req_valid), .req_write(req_write), .req_row(req_row),
        .req_col(req_col), .req_wdata(req_wdata), .req_ready(req_ready), .rd_valid(rd_valid),
        .rd_data(rd_data), .ras_n(ras_n), .cas_n(cas_n), .we_n(we_n), .mem_addr(mem_addr),
        .dq_in(dq_in), .dq_out(dq_out), .dq_oe(dq_oe));

    dmst_mem_model mem (
        .ras_n(ras_n), .cas_n(cas_n), .we_n(we_n), .mem_addr(mem_addr), .dq_out(dq_out),
        .dq_in(dq_in), .refreshes(refreshes));

    task automatic check(input logic [35:0] seen, input logic [35:0] exp);
        compares++;
        if (seen !== exp) begin
            errors++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check

    task automatic final_report;
        $display("compares=%0d errors=%0d", compares, errors);
        if (errors == 0 && compares > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask : final_report

    // Leaves a write request up so the next one can follow back to back
    task automatic access(input logic wr, input logic [8:0] row, input logic [8:0] col, input logic [35:0] d);
        int n;
        n = 0;
        req_valid <= 1'b1;
        req_write <= wr;
        req_row <= row;
        req_col <= col;
        req_wdata <= d;
        do begin @(posedge clk); n++; end while (req_ready !== 1'b1 && n < 800);
        check(36'(n < 800), 36'h1);
        if (wr) ref_mem[{row, col}] = d;
        else begin
            req_valid <= 1'b0;
            n = 0;
            do begin @(posedge clk); n++; end while (rd_valid !== 1'b1 && n < 40);
            check(36'(n < 40), 36'h1);
            check(rd_data, ref_mem[{row, col}]);
        end
    endtask : access

    // Strobe spacing seen at the pins
    always @(posedge clk) begin
        cyc++;
        if (nrst && ras_prev && !ras_n && !cas_n) check(36'(cas_low >= 1), 36'h1);
        if (nrst && !ras_prev && ras_n) check(36'(ras_low >= 4 && ras_low < 400), 36'h1);
        cas_low = cas_n ? 0 : cas_low + 1;
        ras_low = ras_n ? 0 : ras_low + 1;
        ras_prev = ras_n;
        if (cyc == 20000) begin
            errors++;
            final_report();
        end
    end

    initial begin
        seed = 32;
        nrst = 1'b0;
        req_valid = 1'b0;
        req_write = 1'b0;
        req_row = 9'h0;
        req_col = 9'h0;
        req_wdata = 36'h0;
        ras_prev = 1'b1;
        repeat (2) @(posedge clk);
        nrst <= 1'b1;
        @(posedge clk);
        check({ras_n, cas_n, we_n, dq_oe}, 36'he);
        // Few rows so page hits and row misses both occur
        for (i = 0; i < 60; i++) begin
            r = 9'($random(seed) & 3);
            c = 9'($random(seed) & 7);
            access(!ref_mem.exists({r, c}) || ($random(seed) & 1), r, c, 36'({$random(seed), $random(seed)}));
            if ($random(seed) & 4) begin
                req_valid <= 1'b0;
                repeat (3) @(posedge clk);
            end
        end
        req_valid <= 1'b0;
        repeat (450) @(posedge clk);
        access(1'b0, r, c, 36'h0);
        @(posedge clk);
        nrst <= 1'b0;
        @(posedge clk);
        check({ras_n, cas_n, we_n, dq_oe}, 36'he);
        nrst <= 1'b1;
        @(posedge clk);
        access(1'b0, r, c, 36'h0);
        check(36'(refreshes >= cyc / STEP - 4), 36'h1);
        final_report();
    end
endmodule : dram_module_strobe_timing_tb
